// >>> status_event_regs.sv
/*
 * status and event reporting register bank with host command port.
 * assumes the command parser presents one decoded command per cycle
 * on CMD_IN with CMD_VALID_IN, and device events as one-cycle pulses
 * (levels where noted), all synchronous to CLOCK_IN.
 */
`timescale 1ns/10ps

module status_event_regs (
   // clock and reset
   input  wire logic                         CLOCK_IN,
   input  wire logic                         RESETN_IN,
   // host command port
   input  wire logic                         CMD_VALID_IN,
   input  wire logic [status_pkg::CMD_W-1:0] CMD_IN,
   input  wire logic [status_pkg::REG_W-1:0] CMD_DATA_IN,
   output logic                              RESP_VALID_OUT,
   output logic      [status_pkg::REG_W-1:0] RESP_DATA_OUT,
   output logic                              SRQ_OUT,
   // flag sources
   input  wire logic [status_pkg::REG_W-1:0] CAL_ERR_SET_IN,
   input  wire logic [status_pkg::REG_W-1:0] ERR_SET_IN,
   input  wire logic [status_pkg::REG_W-1:0] STATUS_SET_IN,
   input  wire logic [status_pkg::REG_W-1:0] STATUS_CLR_IN,
   // acquisition and command events
   input  wire logic                         ACQ_DONE_IN,
   input  wire logic                         PRETRIG_DONE_IN,
   input  wire logic                         TRIG_CONFIG_IN,
   input  wire logic                         REARM_IN,
   input  wire logic                         READ_EMPTY_IN,
   input  wire logic                         RESPONSE_LOST_IN,
   input  wire logic                         CONFLICT_IN,
   input  wire logic                         EXEC_ERR_IN,
   input  wire logic                         SYNTAX_ERR_IN,
   input  wire logic                         BUF_FILL75_IN
);

   status_pkg::cmd_e  cmd;
   logic              rd_event;
   logic              rd_status;
   logic              rd_cal;
   logic              rd_err;
   logic              sys_reset;
   status_pkg::byte_t ev_set;
   status_pkg::byte_t ev_clr;
   status_pkg::byte_t status_q;
   status_pkg::byte_t status_d;
   status_pkg::byte_t summary;
   status_pkg::byte_t resp_data_d;
   logic              resp_valid_d;
   logic              event_summary_bit;
   logic              srq_cond;
   logic              srq_q;
   logic              srq_fresh;
   logic              new_error;

   flag_if cal_f ();
   flag_if err_f ();
   flag_if ev_f ();
   mask_if evm_m ();
   mask_if rqm_m ();

   // command decode
   assign cmd       = status_pkg::cmd_e'(CMD_IN);
   assign rd_event  = CMD_VALID_IN && (cmd == status_pkg::CMD_QUERY_EVENT);
   assign rd_status = CMD_VALID_IN && (cmd == status_pkg::CMD_QUERY_STATUS);
   assign rd_cal    = CMD_VALID_IN && (cmd == status_pkg::CMD_QUERY_CAL);
   assign rd_err    = CMD_VALID_IN && (cmd == status_pkg::CMD_QUERY_ERR);
   assign sys_reset = CMD_VALID_IN && (cmd == status_pkg::CMD_SYS_RESET);

   // calibration flags: set only by the calibration engine
   assign cal_f.set_vec = CAL_ERR_SET_IN;
   assign cal_f.clr_vec = rd_cal ? status_pkg::ALL_ONES : status_pkg::NONE;

   flag_reg #(
      .RESET_VAL (status_pkg::CAL_RST)
   ) u_cal_flags (
      .clk_in   (CLOCK_IN),
      .rst_n_in (RESETN_IN),
      .f        (cal_f)
   );

   // a standing calibration flag re-asserts the error origin bit, so reading
   // the error flags cannot hide an uncorrected calibration fault
   always_comb begin
      err_f.set_vec = ERR_SET_IN;
      if (cal_f.value != status_pkg::NONE) begin
         err_f.set_vec[status_pkg::ERR_CAL_BIT] = 1'b1;
      end
   end
   assign err_f.clr_vec = rd_err ? status_pkg::ALL_ONES : status_pkg::NONE;

   flag_reg #(
      .RESET_VAL (status_pkg::ERR_RST)
   ) u_err_flags (
      .clk_in   (CLOCK_IN),
      .rst_n_in (RESETN_IN),
      .f        (err_f)
   );

   // only a newly set origin bit counts, otherwise the standing
   // calibration bit would flood the event flag every cycle
   assign new_error = |(err_f.set_vec & ~err_f.value);

   // event flag sources; the event mask is deliberately not used here
   always_comb begin
      ev_set = status_pkg::NONE;
      ev_set[status_pkg::EV_ACQ_DONE]  = ACQ_DONE_IN;
      ev_set[status_pkg::EV_PRETRIG]   = PRETRIG_DONE_IN;
      ev_set[status_pkg::EV_QUERY_ERR] = READ_EMPTY_IN | RESPONSE_LOST_IN;
      ev_set[status_pkg::EV_CONFLICT]  = CONFLICT_IN;
      ev_set[status_pkg::EV_EXEC_ERR]  = EXEC_ERR_IN;
      ev_set[status_pkg::EV_FROM_ERR]  = ev_set[status_pkg::EV_FROM_ERR] | new_error;
      ev_set[status_pkg::EV_SYNTAX]    = SYNTAX_ERR_IN;
      ev_set[status_pkg::EV_FILL75]    = BUF_FILL75_IN;
      ev_set[status_pkg::EV_POWER_ON]  = sys_reset;
   end

   always_comb begin
      ev_clr = status_pkg::NONE;
      if (rd_event || sys_reset) begin
         ev_clr = status_pkg::ALL_ONES;
      end
      ev_clr[status_pkg::EV_ACQ_DONE] = ev_clr[status_pkg::EV_ACQ_DONE] | TRIG_CONFIG_IN;
      ev_clr[status_pkg::EV_PRETRIG]  = ev_clr[status_pkg::EV_PRETRIG]
                                        | TRIG_CONFIG_IN | REARM_IN;
      ev_clr[status_pkg::EV_FILL75]   = ev_clr[status_pkg::EV_FILL75] | ~BUF_FILL75_IN;
   end

   assign ev_f.set_vec = ev_set;
   assign ev_f.clr_vec = ev_clr;

   flag_reg #(
      .RESET_VAL (status_pkg::EVENT_RST)
   ) u_event_flags (
      .clk_in   (CLOCK_IN),
      .rst_n_in (RESETN_IN),
      .f        (ev_f)
   );

   // host masks
   assign evm_m.wr    = CMD_VALID_IN && (cmd == status_pkg::CMD_WRITE_EVMASK);
   assign evm_m.clr   = sys_reset || (CMD_VALID_IN && (cmd == status_pkg::CMD_CLEAR_EVMASK));
   assign evm_m.wdata = CMD_DATA_IN;
   assign rqm_m.wr    = CMD_VALID_IN && (cmd == status_pkg::CMD_WRITE_RQMASK);
   assign rqm_m.clr   = sys_reset || (CMD_VALID_IN && (cmd == status_pkg::CMD_CLEAR_RQMASK));
   assign rqm_m.wdata = CMD_DATA_IN;

   mask_reg u_event_mask (
      .clk_in   (CLOCK_IN),
      .rst_n_in (RESETN_IN),
      .m        (evm_m)
   );

   mask_reg u_request_mask (
      .clk_in   (CLOCK_IN),
      .rst_n_in (RESETN_IN),
      .m        (rqm_m)
   );

   // summary status: internally set and cleared bits, host cannot write
   always_comb begin
      status_d = (status_q & ~STATUS_CLR_IN) | STATUS_SET_IN;
      if (rd_status || sys_reset) begin
         status_d = STATUS_SET_IN;
      end
      status_d = status_d & status_pkg::STORED_MASK;
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
         status_q <= status_pkg::STAT_RST;
      end else begin
         status_q <= status_d;
      end
   end

   // derived live, so clearing event flags drops the summary bit at once
   assign event_summary_bit = |(ev_f.value & evm_m.value);

   always_comb begin
      summary                     = status_q;
      summary[status_pkg::ST_EVSUM] = event_summary_bit;
      summary[status_pkg::ST_SRQ] = srq_q;
   end

   // the request bit itself never feeds back into the request
   assign srq_cond = |(summary & rqm_m.value & status_pkg::NO_SRQ_MASK);

   // a clear looks at the status left after it, so the stale bits that it
   // wipes cannot hold the request up; a bit set in that same cycle still wins on a status read, but not on a system reset
   assign srq_fresh = !sys_reset
                      && (|(status_d & rqm_m.value & status_pkg::NO_SRQ_MASK));

   always_ff @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
         srq_q <= 1'b0;
      end else if (rd_status || sys_reset) begin
         srq_q <= srq_fresh;
      end else if (srq_cond) begin
         srq_q <= 1'b1;
      end
   end

   assign SRQ_OUT = srq_q;

   // response path: value before any clear of this same cycle
   always_comb begin
      resp_valid_d = CMD_VALID_IN;
      resp_data_d  = status_pkg::NONE;
      unique case (cmd)
         status_pkg::CMD_QUERY_EVENT:  resp_data_d = ev_f.value;
         status_pkg::CMD_QUERY_STATUS: resp_data_d = summary;
         status_pkg::CMD_QUERY_CAL:    resp_data_d = cal_f.value;
         status_pkg::CMD_QUERY_ERR:    resp_data_d = err_f.value;
         status_pkg::CMD_QUERY_EVMASK: resp_data_d = evm_m.value;
         status_pkg::CMD_QUERY_RQMASK: resp_data_d = rqm_m.value;
         status_pkg::CMD_NONE,
         status_pkg::CMD_WRITE_EVMASK,
         status_pkg::CMD_WRITE_RQMASK,
         status_pkg::CMD_CLEAR_EVMASK,
         status_pkg::CMD_CLEAR_RQMASK,
         status_pkg::CMD_SYS_RESET:    resp_valid_d = 1'b0;
         default:                      resp_valid_d = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
         RESP_VALID_OUT <= 1'b0;
         RESP_DATA_OUT  <= status_pkg::NONE;
      end else begin
         RESP_VALID_OUT <= resp_valid_d;
         RESP_DATA_OUT  <= resp_data_d;
      end
   end

   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   sequence s_event_query;
      rd_event && (ev_set == status_pkg::NONE);
   endsequence

   sequence s_flags_empty;
      (ev_f.value == status_pkg::NONE) && !event_summary_bit;
   endsequence

   sequence s_sys_reset;
      sys_reset && (ev_set == 8'h80);
   endsequence

   chk_event_read_clear: assert property (s_event_query |=> s_flags_empty)
      else $error("event flags not cleared after query");
   chk_event_query_data: assert property (rd_event |=> RESP_VALID_OUT
                                          && (RESP_DATA_OUT == $past(ev_f.value)))
      else $error("event query returned wrong data");
   chk_mask_write_store: assert property (evm_m.wr && !evm_m.clr
                                          |=> evm_m.value == $past(CMD_DATA_IN))
      else $error("event mask write not stored");
   chk_mask_clear: assert property (rqm_m.clr |=> rqm_m.value == status_pkg::NONE)
      else $error("request mask not cleared");
   chk_cal_to_err: assert property (cal_f.value != status_pkg::NONE
                                    |=> err_f.value[status_pkg::ERR_CAL_BIT])
      else $error("calibration fault missing in error origin");
   chk_err_to_event: assert property (new_error |=> ev_f.value[status_pkg::EV_FROM_ERR])
      else $error("error origin did not set event flag");
   chk_acq_clear: assert property (TRIG_CONFIG_IN && !ACQ_DONE_IN
                                   |=> !ev_f.value[status_pkg::EV_ACQ_DONE])
      else $error("acquisition flag survived trigger config");
   chk_fill_track: assert property (##1 ev_f.value[status_pkg::EV_FILL75]
                                    == $past(BUF_FILL75_IN))
      else $error("fill flag does not follow occupancy");
   chk_evsum_status: assert property (rd_status && event_summary_bit
                                      |=> RESP_DATA_OUT[status_pkg::ST_EVSUM])
      else $error("summary bit missing from status read");
   chk_srq_raise_hold: assert property (srq_cond && !(rd_status || sys_reset) |=> SRQ_OUT
                                        ##1 (SRQ_OUT || $past(rd_status || sys_reset)))
      else $error("service request not raised or not held");
   chk_srq_query_clear: assert property ((rd_status || sys_reset) && !srq_fresh
                                         |=> !SRQ_OUT)
      else $error("service request survived status clear");
   chk_power_on_set: assert property (s_sys_reset |=> ev_f.value == 8'h80
                                      && evm_m.value == status_pkg::NONE)
      else $error("system reset did not restore defaults");
   chk_status_ro: assert property ((evm_m.wr || rqm_m.wr) && (STATUS_SET_IN == 8'h00)
                                   && (STATUS_CLR_IN == 8'h00)
                                   |=> status_q == $past(status_q))
      else $error("host write changed summary status");

endmodule

// >>> status_pkg.sv
/*
 * shared constants for the status and event reporting block: widths,
 * bit positions, reset values and the host command codes.
 * assumes nothing of its surroundings.
 */
package status_pkg;

   localparam int REG_W = 8;
   typedef logic [REG_W-1:0] byte_t;

   // event flag positions
   localparam int EV_ACQ_DONE  = 0;
   localparam int EV_PRETRIG   = 1;
   localparam int EV_QUERY_ERR = 2;
   localparam int EV_CONFLICT  = 3;
   localparam int EV_EXEC_ERR  = 4;
   localparam int EV_SYNTAX    = 5;
   localparam int EV_FILL75    = 6;
   localparam int EV_POWER_ON  = 7;

   // summary status positions, weights 1 to 128
   localparam int ST_ALARM    = 0;
   localparam int ST_TRIGGER  = 1;
   localparam int ST_READY    = 2;
   localparam int ST_SCAN     = 3;
   localparam int ST_MESSAGE  = 4;
   localparam int ST_EVSUM    = 5;
   localparam int ST_SRQ      = 6;
   localparam int ST_OVERRUN  = 7;

   // error origin bit fed by any calibration flag
   localparam int ERR_CAL_BIT = 0;
   // event flag that an error origin setting lands in
   localparam int EV_FROM_ERR = EV_EXEC_ERR;

   localparam byte_t ALL_ONES    = 8'hFF;
   localparam byte_t NONE        = 8'h00;
   localparam byte_t STORED_MASK = 8'h9F;
   localparam byte_t NO_SRQ_MASK = 8'hBF;

   localparam byte_t CAL_RST   = 8'h00;
   localparam byte_t ERR_RST   = 8'h00;
   localparam byte_t EVENT_RST = 8'h80;
   localparam byte_t STAT_RST  = 8'h00;
   localparam byte_t MASK_RST  = 8'h00;

   localparam int CMD_W = 4;
   typedef enum logic [CMD_W-1:0] {
      CMD_NONE,
      CMD_QUERY_EVENT,
      CMD_QUERY_STATUS,
      CMD_QUERY_CAL,
      CMD_QUERY_ERR,
      CMD_QUERY_EVMASK,
      CMD_QUERY_RQMASK,
      CMD_WRITE_EVMASK,
      CMD_WRITE_RQMASK,
      CMD_CLEAR_EVMASK,
      CMD_CLEAR_RQMASK,
      CMD_SYS_RESET
   } cmd_e;

endpackage

// >>> status_if.sv
/*
 * carriers between the top and its flag and mask registers.
 * assumes one clock owned by the instantiating module.
 */
`timescale 1ns/10ps

interface flag_if;
   status_pkg::byte_t set_vec;
   status_pkg::byte_t clr_vec;
   status_pkg::byte_t value;
   modport owner (input set_vec, input clr_vec, output value);
   modport user  (output set_vec, output clr_vec, input value);
endinterface

interface mask_if;
   logic              wr;
   logic              clr;
   status_pkg::byte_t wdata;
   status_pkg::byte_t value;
   modport owner (input wr, input clr, input wdata, output value);
   modport user  (output wr, output clr, output wdata, input value);
endinterface

// >>> flag_reg.sv
/*
 * eight sticky flags, set by hardware events, cleared by vector.
 * assumes set and clear vectors synchronous to clk_in.
 */
`timescale 1ns/10ps

module flag_reg #(
   parameter status_pkg::byte_t RESET_VAL = status_pkg::NONE
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // flag access
   flag_if.owner    f
);

   // a set arriving with its clear is kept
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         f.value <= RESET_VAL;
      end else begin
         f.value <= (f.value & ~f.clr_vec) | f.set_vec;
      end
   end

endmodule

// >>> mask_reg.sv
/*
 * eight-bit host mask: full-value write, clear, read.
 * assumes wr and clr are one-cycle strobes on clk_in.
 */
`timescale 1ns/10ps

module mask_reg (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // mask access
   mask_if.owner    m
);

   // clear has priority so a reset command overrides a stale write
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         m.value <= status_pkg::MASK_RST;
      end else if (m.clr) begin
         m.value <= status_pkg::NONE;
      end else if (m.wr) begin
         m.value <= m.wdata;
      end
   end

endmodule

// >>> host_model.sv
/*
 * host controller model: issues one decoded command at a time and
 * captures the answer one cycle after the command is driven.
 * assumes the block samples commands on the rising edge of clk_in.
 */
`timescale 1ns/10ps

module host_model (
   // clock
   input  wire logic                         clk_in,
   // answer from the block
   input  wire logic                         resp_valid_in,
   input  wire logic [status_pkg::REG_W-1:0] resp_data_in,
   // command to the block
   output logic                              cmd_valid_out,
   output logic      [status_pkg::CMD_W-1:0] cmd_out,
   output logic      [status_pkg::REG_W-1:0] cmd_data_out
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_out       = status_pkg::CMD_NONE;
      cmd_data_out  = 8'h00;
   end

   // mask writes carry the full value with the command
   task automatic send(input  logic [status_pkg::CMD_W-1:0] c,
                       input  status_pkg::byte_t            d,
                       output logic                         v,
                       output status_pkg::byte_t            r);
      @(posedge clk_in);
      #1;
      cmd_valid_out = 1'b1;
      cmd_out       = c;
      cmd_data_out  = d;
      @(posedge clk_in);
      #1;
      v             = resp_valid_in;
      r             = resp_data_in;
      cmd_valid_out = 1'b0;
      cmd_out       = status_pkg::CMD_NONE;
      // released data lines must not keep showing the last value
      cmd_data_out  = ~d;
   endtask
endmodule

// >>> status_event_regs_tb.sv
/*
 * self-checking bench for the status and event reporting bank.
 * assumes the host model drives commands and this module drives events.
 */
`timescale 1ns/10ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end

module status_event_regs_tb;
   logic              clk;
   logic              rst_n;
   logic              cmd_valid;
   logic [3:0]        cmd;
   logic [7:0]        cmd_data;
   logic              resp_valid;
   logic [7:0]        resp_data;
   logic              srq;
   logic [8:0]        ev;
   status_pkg::byte_t cal_set;
   status_pkg::byte_t err_set;
   status_pkg::byte_t st_set;
   status_pkg::byte_t st_clr;
   logic              fill;
   int                n_errors;
   int                n_checks;

   host_model host (
      .clk_in        (clk),
      .resp_valid_in (resp_valid),
      .resp_data_in  (resp_data),
      .cmd_valid_out (cmd_valid),
      .cmd_out       (cmd),
      .cmd_data_out  (cmd_data)
   );

   status_event_regs i_status_event_regs (
      .CLOCK_IN         (clk),
      .RESETN_IN        (rst_n),
      .CMD_VALID_IN     (cmd_valid),
      .CMD_IN           (cmd),
      .CMD_DATA_IN      (cmd_data),
      .RESP_VALID_OUT   (resp_valid),
      .RESP_DATA_OUT    (resp_data),
      .SRQ_OUT          (srq),
      .CAL_ERR_SET_IN   (cal_set),
      .ERR_SET_IN       (err_set),
      .STATUS_SET_IN    (st_set),
      .STATUS_CLR_IN    (st_clr),
      .ACQ_DONE_IN      (ev[0]),
      .PRETRIG_DONE_IN  (ev[1]),
      .TRIG_CONFIG_IN   (ev[6]),
      .REARM_IN         (ev[7]),
      .READ_EMPTY_IN    (ev[2]),
      .RESPONSE_LOST_IN (ev[8]),
      .CONFLICT_IN      (ev[3]),
      .EXEC_ERR_IN      (ev[4]),
      .SYNTAX_ERR_IN    (ev[5]),
      .BUF_FILL75_IN    (fill)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // query: an answer must come with the expected byte
   task automatic q(input logic [3:0] c, input status_pkg::byte_t e);
      logic              v;
      status_pkg::byte_t r;
      host.send(c, 8'h00, v, r);
      `CHK("resp_valid", 1'b1, v)
      `CHK("resp_data", e, r)
   endtask

   // write, clear or refused code: no answer may come
   task automatic w(input logic [3:0] c, input status_pkg::byte_t d);
      logic              v;
      status_pkg::byte_t r;
      host.send(c, d, v, r);
      `CHK("no_resp", 1'b0, v)
   endtask

   task automatic pulse(input logic [8:0] e, input status_pkg::byte_t c,
                        input status_pkg::byte_t er, input status_pkg::byte_t s,
                        input status_pkg::byte_t sc);
      @(posedge clk);
      #1;
      {ev, cal_set, err_set, st_set, st_clr} = {e, c, er, s, sc};
      @(posedge clk);
      #1;
      {ev, cal_set, err_set, st_set, st_clr} = '0;
   endtask

   initial begin
      #300000;
      n_errors++;
      end_sim();
   end

   initial begin
      logic [8:0]        src [7];
      status_pkg::byte_t exp [7];
      src = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h100};
      exp = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h04};
      n_errors = 0;
      n_checks = 0;
      rst_n = 1'b0;
      {ev, cal_set, err_set, st_set, st_clr, fill} = '0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      `CHK("srq_reset", 1'b0, srq)
      q(status_pkg::CMD_QUERY_EVENT, status_pkg::EVENT_RST);
      q(status_pkg::CMD_QUERY_EVENT, 8'h00);
      q(status_pkg::CMD_QUERY_STATUS, 8'h00);
      q(status_pkg::CMD_QUERY_CAL, 8'h00);
      q(status_pkg::CMD_QUERY_ERR, 8'h00);
      q(status_pkg::CMD_QUERY_EVMASK, 8'h00);
      q(status_pkg::CMD_QUERY_RQMASK, 8'h00);
      // each of seven event sources lands in its bit (read empty and response lost share one) and reads back once
      for (int i = 0; i < 7; i++) begin
         pulse(src[i], 8'h00, 8'h00, 8'h00, 8'h00);
         q(status_pkg::CMD_QUERY_EVENT, exp[i]);
         q(status_pkg::CMD_QUERY_EVENT, 8'h00);
      end
      // rearm drops only the pretrigger bit, trigger config drops both
      pulse(9'h003, 8'h00, 8'h00, 8'h00, 8'h00);
      pulse(9'h080, 8'h00, 8'h00, 8'h00, 8'h00);
      q(status_pkg::CMD_QUERY_EVENT, 8'h01);
      pulse(9'h003, 8'h00, 8'h00, 8'h00, 8'h00);
      pulse(9'h040, 8'h00, 8'h00, 8'h00, 8'h00);
      q(status_pkg::CMD_QUERY_EVENT, 8'h00);
      fill = 1'b1;
      q(status_pkg::CMD_QUERY_EVENT, 8'h40);
      q(status_pkg::CMD_QUERY_EVENT, 8'h40);
      fill = 1'b0;
      q(status_pkg::CMD_QUERY_EVENT, 8'h00);
      // calibration flag ripples down into error origin and event flags
      pulse(9'h000, 8'h08, 8'h00, 8'h00, 8'h00);
      q(status_pkg::CMD_QUERY_CAL, 8'h08);
      q(status_pkg::CMD_QUERY_CAL, 8'h00);
      q(status_pkg::CMD_QUERY_ERR, 8'h01);
      q(status_pkg::CMD_QUERY_EVENT, 8'h10);
      pulse(9'h000, 8'h00, 8'h20, 8'h00, 8'h00);
      q(status_pkg::CMD_QUERY_ERR, 8'h20);
      q(status_pkg::CMD_QUERY_ERR, 8'h00);
      q(status_pkg::CMD_QUERY_EVENT, 8'h10);
      // mask registers: full-value write, read, clear
      w(status_pkg::CMD_WRITE_EVMASK, 8'hA5);
      q(status_pkg::CMD_QUERY_EVMASK, 8'hA5);
      w(status_pkg::CMD_CLEAR_EVMASK, 8'h00);
      q(status_pkg::CMD_QUERY_EVMASK, 8'h00);
      w(status_pkg::CMD_WRITE_RQMASK, 8'h3C);
      q(status_pkg::CMD_QUERY_RQMASK, 8'h3C);
      w(status_pkg::CMD_CLEAR_RQMASK, 8'h00);
      q(status_pkg::CMD_QUERY_RQMASK, 8'h00);
      // refused codes change nothing and give no answer
      w(4'hF, 8'h55);
      w(status_pkg::CMD_NONE, 8'h55);
      q(status_pkg::CMD_QUERY_EVENT, 8'h00);
      q(status_pkg::CMD_QUERY_EVMASK, 8'h00);
      // summary bit follows enabled event flags only
      w(status_pkg::CMD_WRITE_EVMASK, 8'h20);
      pulse(9'h010, 8'h00, 8'h00, 8'h00, 8'h00);
      q(status_pkg::CMD_QUERY_STATUS, 8'h00);
      pulse(9'h020, 8'h00, 8'h00, 8'h00, 8'h00);
      q(status_pkg::CMD_QUERY_STATUS, 8'h20);
      q(status_pkg::CMD_QUERY_EVENT, 8'h30);
      q(status_pkg::CMD_QUERY_STATUS, 8'h00);
      // service request from a stored status bit
      pulse(9'h000, 8'h00, 8'h00, 8'h01, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      `CHK("srq_unmasked", 1'b0, srq)
      w(status_pkg::CMD_WRITE_RQMASK, 8'h01);
      @(posedge clk);
      #1;
      `CHK("srq_set", 1'b1, srq)
      q(status_pkg::CMD_QUERY_STATUS, 8'h41);
      `CHK("srq_clear", 1'b0, srq)
      q(status_pkg::CMD_QUERY_STATUS, 8'h00);
      // service request through the summary bit, withdrawn from above
      w(status_pkg::CMD_WRITE_RQMASK, 8'h20);
      w(status_pkg::CMD_WRITE_EVMASK, 8'h04);
      pulse(9'h004, 8'h00, 8'h00, 8'h00, 8'h00);
      @(posedge clk);
      #1;
      `CHK("srq_evsum", 1'b1, srq)
      q(status_pkg::CMD_QUERY_EVENT, 8'h04);
      q(status_pkg::CMD_QUERY_STATUS, 8'h40);
      `CHK("srq_drop", 1'b0, srq)
      // system reset restores power-on event, status and mask state
      pulse(9'h000, 8'h00, 8'h00, 8'h80, 8'h00);
      w(status_pkg::CMD_SYS_RESET, 8'h00);
      q(status_pkg::CMD_QUERY_EVENT, 8'h80);
      q(status_pkg::CMD_QUERY_STATUS, 8'h00);
      q(status_pkg::CMD_QUERY_EVMASK, 8'h00);
      q(status_pkg::CMD_QUERY_RQMASK, 8'h00);
      // internal clear path of the summary status
      pulse(9'h000, 8'h00, 8'h00, 8'h88, 8'h00);
      pulse(9'h000, 8'h00, 8'h00, 8'h00, 8'h08);
      q(status_pkg::CMD_QUERY_STATUS, 8'h80);
      end_sim();
   end
endmodule
